/* rst_suspend_ctrl.sv */
// brown-out, watchdog and suspend sequencing for the core
// Functional notes
// RL1: brown-out always watched, forces reset
// RL2: after trip, hold until above undervolt_threshold, delay
// RL3: suspend relies on brown-out only
// RL4: any write to 0x26 clears watchdog
// RL5: uncleared watchdog rolls over, resets core
// RL6: watchdog reset sets status bit 6
// RL7: watchdog reset holds core about 2 ms
// RL8: suspend bit write enters suspend
// RL9: suspend stops oscillators, timers and watchdog
// RL10: only listed wake sources end suspend
// RL11: resume after oscillator stable plus delay
// RL12: enabled pending interrupt wakes, sense bit ignored
// RL13: pending wake still enters suspend first
// RL14: resume requires run bit set
// RL15: next instruction runs before any interrupt
// RL16: firmware writes 09h to FFh to suspend
// RL17: wake clock follows external oscillator enable
// RL18: firmware disables unwanted interrupts before suspend
// RL19: external clock resume 4 ms or 128 us
// RL20: internal clock resume about 8 us
// RL21: undervolt reset off in suspend, restored after
// RL22: resume counted on restarted clock, core gated
`timescale 1ns/1ns
`include "rst_pwr_consts.svh"
module rst_suspend_ctrl #(
	parameter int START_CYC    = `T_START_US * `CLK_MHZ,
	parameter int WDOG_HOLD_CYC = `T_WDOG_HOLD_MS * 1000 * `CLK_MHZ,
	parameter int WATCH_CYC    = `T_WATCH_MS * 1000 * `CLK_MHZ,
	parameter int RES_LONG_CYC = `T_RES_EXT_LONG_US * `CLK_MHZ,
	parameter int RES_SHORT_CYC = `T_RES_EXT_SHORT_US * `CLK_MHZ
) (
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	input  wire logic                 supply_drop_detect,
	input  wire logic                 undervolt_detect,
	input  wire logic                 ps2_serial_data_pin,
	input  wire logic                 osc_stable,
	input  wire rst_pwr_pkg::io_req_t io_req,
	input  wire rst_pwr_pkg::wake_src_t wake_src,
	input  wire logic                 core_instr_done,
	output logic [7:0]                io_rdata,
	output logic                      core_rst,
	output logic                      core_clk_en,
	output logic                      osc_run,
	output logic                      ext_osc_sel,
	output logic                      timers_run,
	output logic                      undervolt_reset_armed,
	output logic                      irq_defer
);
	localparam int TW          = 20;
	localparam int RES_INT_CYC = `T_RES_INT_US * `CLK_MHZ;

	rst_pwr_pkg::pwr_state_t st;
	logic [7:0]  proc_status;
	logic [7:0]  clk_cfg;
	logic [1:0]  drop_sync;
	logic [1:0]  uv_sync;
	logic [1:0]  dm_sync;
	logic [1:0]  osc_sync;
	logic        drop_lvl;
	logic        uv_lvl;
	logic        dm_low;
	logic        osc_ok;
	logic        uv_armed;
	logic        brown;
	logic        wake;
	logic        run_wr;
	logic        wd_clear;
	logic        wd_roll;
	logic [23:0] wd_cnt;
	logic        susp_req;
	logic        tm_start;
	logic [TW-1:0] tm_len;
	logic        tm_busy;
	logic        tm_done;
	logic        osc_lost;
	logic [TW-1:0] res_cnt;

	// two-stage synchronisers for analog and pin levels
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			drop_sync <= 2'h0;
			uv_sync   <= 2'h0;
			dm_sync   <= 2'h3;
			osc_sync  <= 2'h0;
		end else begin
			drop_sync <= {drop_sync[0], supply_drop_detect};
			uv_sync   <= {uv_sync[0], undervolt_detect};
			dm_sync   <= {dm_sync[0], ps2_serial_data_pin};
			osc_sync  <= {osc_sync[0], osc_stable};
		end
	end

	assign drop_lvl = drop_sync[1];
	assign uv_lvl   = uv_sync[1];
	assign dm_low   = ~dm_sync[1];
	assign osc_ok   = osc_sync[1];

	// a stale stable level from before suspend must not start the resume
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) osc_lost <= 1'b0;
		else if (!osc_ok) osc_lost <= 1'b1; // RL11
		else if (st == rst_pwr_pkg::ST_RUN) osc_lost <= 1'b0;
	end

	// undervolt reset idles in suspend and comes back after it
	assign uv_armed = ~clk_cfg[`CC_UV_DIS_BIT]
		& ~(st inside {rst_pwr_pkg::ST_SUSPEND, rst_pwr_pkg::ST_OSC_WAIT}); // RL21
	// brown-out is never masked; undervolt only when armed
	assign brown = drop_lvl | (uv_armed & uv_lvl); // RL1 RL3

	// wake sources; the global interrupt sense bit plays no part
	assign wake = (|(wake_src.irq_pend & wake_src.irq_en)) | wake_src.spi_irq | dm_low; // RL10 RL12

	// register writes only land while the core runs
	assign run_wr   = io_req.wr & (st == rst_pwr_pkg::ST_RUN);
	assign wd_clear = run_wr & (io_req.addr == `ADDR_WDOG_CLEAR); // RL4
	assign susp_req = run_wr & (io_req.addr == `ADDR_PROC_STATUS)
		& io_req.data[`PS_SUSPEND_BIT]; // RL8 RL16

	// timer launch points and lengths
	always_comb begin
		tm_start = 1'b0;
		tm_len   = TW'(START_CYC);
		if (!brown) begin
			if (st == rst_pwr_pkg::ST_SUPPLY_HOLD && !drop_lvl && !uv_lvl) begin
				tm_start = 1'b1; // RL2
			end else if (st == rst_pwr_pkg::ST_RUN && wd_roll) begin
				tm_start = 1'b1;
				tm_len   = TW'(WDOG_HOLD_CYC); // RL7
			end else if (st == rst_pwr_pkg::ST_OSC_WAIT && osc_ok && osc_lost) begin
				tm_start = 1'b1; // RL11 RL22
				if (!ext_osc_sel) begin
					tm_len = TW'(RES_INT_CYC); // RL20
				end else if (clk_cfg[`CC_RES_DLY_BIT]) begin
					tm_len = TW'(RES_LONG_CYC); // RL19
				end else begin
					tm_len = TW'(RES_SHORT_CYC); // RL19
				end
			end
		end
	end

	span_timer #(.W(TW)) u_span (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.start   (tm_start),
		.abort   (brown),
		.len     (tm_len),
		.busy    (tm_busy),
		.done    (tm_done)
	);

	// watchdog is frozen outside normal running
	watchdog_timer #(.W(24), .PERIOD(WATCH_CYC)) u_wdog (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.run     (st == rst_pwr_pkg::ST_RUN), // RL9
		.clear   (wd_clear),
		.count   (wd_cnt),
		.roll    (wd_roll)
	);

	// power and reset sequencer
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st <= rst_pwr_pkg::ST_SUPPLY_HOLD;
		end else if (brown) begin
			st <= rst_pwr_pkg::ST_SUPPLY_HOLD; // RL1
		end else begin
			unique case (st)
				rst_pwr_pkg::ST_SUPPLY_HOLD: begin
					if (tm_start) st <= rst_pwr_pkg::ST_START; // RL2
				end
				rst_pwr_pkg::ST_START: begin
					if (tm_done) st <= rst_pwr_pkg::ST_RUN;
				end
				rst_pwr_pkg::ST_RUN: begin
					if (wd_roll) begin
						st <= rst_pwr_pkg::ST_WDOG_HOLD; // RL5
					end else if (susp_req) begin
						st <= rst_pwr_pkg::ST_SUSPEND; // RL8 RL13
					end
				end
				rst_pwr_pkg::ST_SUSPEND: begin
					if (wake && proc_status[`PS_RUN_BIT]) st <= rst_pwr_pkg::ST_OSC_WAIT; // RL14
				end
				rst_pwr_pkg::ST_OSC_WAIT: begin
					if (tm_start) st <= rst_pwr_pkg::ST_RES_DELAY; // RL11
				end
				rst_pwr_pkg::ST_RES_DELAY: begin
					if (tm_done) st <= rst_pwr_pkg::ST_RUN; // RL11
				end
				rst_pwr_pkg::ST_WDOG_HOLD: begin
					if (tm_done) st <= rst_pwr_pkg::ST_RUN; // RL7
				end
			endcase
		end
	end

	// processor status and control register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			proc_status <= `PS_RESET_VAL;
		end else if (brown) begin
			proc_status <= `PS_RESET_VAL; // RL2
		end else if (st == rst_pwr_pkg::ST_RUN && wd_roll) begin
			proc_status <= 8'h01 | (proc_status & 8'h10) | (8'h01 << `PS_WDOG_BIT); // RL6
		end else if (st == rst_pwr_pkg::ST_RES_DELAY && tm_done) begin
			proc_status[`PS_SUSPEND_BIT] <= 1'b0;
		end else if (run_wr && io_req.addr == `ADDR_PROC_STATUS) begin
			proc_status <= io_req.data;
		end
	end

	// clock configuration register; cleared by every reset
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			clk_cfg <= `CC_RESET_VAL;
		end else if (brown || (st == rst_pwr_pkg::ST_RUN && wd_roll)) begin
			clk_cfg <= `CC_RESET_VAL;
		end else if (run_wr && io_req.addr == `ADDR_CLK_CFG) begin
			clk_cfg <= io_req.data;
		end
	end

	// read port, one cycle after the strobe
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			io_rdata <= 8'h00;
		end else if (io_req.rd) begin
			unique case (io_req.addr)
				`ADDR_PROC_STATUS: io_rdata <= proc_status;
				`ADDR_CLK_CFG:     io_rdata <= clk_cfg;
				default:           io_rdata <= 8'h00;
			endcase
		end
	end

	// wake clock source is latched only at suspend exit
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ext_osc_sel <= 1'b0;
		end else if (brown) begin
			ext_osc_sel <= 1'b0;
		end else if (st == rst_pwr_pkg::ST_SUSPEND && wake && proc_status[`PS_RUN_BIT]) begin
			ext_osc_sel <= clk_cfg[`CC_EXT_OSC_BIT]; // RL17
		end
	end

	// first instruction after wake runs ahead of interrupts
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq_defer <= 1'b0;
		end else if (brown) begin
			irq_defer <= 1'b0;
		end else if (st == rst_pwr_pkg::ST_RES_DELAY && tm_done) begin
			irq_defer <= 1'b1; // RL15
		end else if (core_instr_done) begin
			irq_defer <= 1'b0;
		end
	end

	// core and clock controls follow the state one cycle later
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			core_rst              <= 1'b1;
			core_clk_en           <= 1'b0;
			osc_run               <= 1'b1;
			timers_run            <= 1'b0;
			undervolt_reset_armed <= 1'b1;
		end else begin
			core_rst <= st inside {rst_pwr_pkg::ST_SUPPLY_HOLD, rst_pwr_pkg::ST_START,
				rst_pwr_pkg::ST_WDOG_HOLD}; // RL2 RL7
			core_clk_en           <= (st == rst_pwr_pkg::ST_RUN); // RL22
			osc_run               <= (st != rst_pwr_pkg::ST_SUSPEND); // RL9
			timers_run            <= (st == rst_pwr_pkg::ST_RUN); // RL9
			undervolt_reset_armed <= uv_armed; // RL21
		end
	end

	// cycles spent in the resume delay, read by the length check
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) res_cnt <= '0;
		else res_cnt <= (st == rst_pwr_pkg::ST_RES_DELAY) ? res_cnt + TW'(1) : '0;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_brown_forces_hold: assert property (drop_lvl |=> st == rst_pwr_pkg::ST_SUPPLY_HOLD) // RL1
		else $error("brown-out did not force reset hold");
	a_hold_until_good: assert property (st == rst_pwr_pkg::ST_SUPPLY_HOLD && uv_lvl
		|=> st == rst_pwr_pkg::ST_SUPPLY_HOLD) // RL2
		else $error("left reset hold with supply low");
	a_suspend_ignores_uv: assert property (st == rst_pwr_pkg::ST_SUSPEND && uv_lvl && !drop_lvl
		&& !wake |=> st == rst_pwr_pkg::ST_SUSPEND) // RL3
		else $error("undervolt reset acted during suspend");
	a_wdog_clear_zero: assert property (wd_clear |=> wd_cnt == 24'h000000) // RL4
		else $error("watchdog clear did not restart count");
	a_roll_to_hold: assert property (wd_roll && st == rst_pwr_pkg::ST_RUN && !brown
		|=> st == rst_pwr_pkg::ST_WDOG_HOLD ##1 core_rst) // RL5
		else $error("watchdog rollover did not reset core");
	a_wdog_flag_set: assert property (wd_roll && st == rst_pwr_pkg::ST_RUN && !brown
		|=> proc_status[`PS_WDOG_BIT] && !clk_cfg[`CC_EXT_OSC_BIT]) // RL6
		else $error("watchdog flag not recorded");
	a_wdog_hold_len: assert property (st == rst_pwr_pkg::ST_RUN && wd_roll && !brown
		|=> tm_busy [*8]) // RL7
		else $error("watchdog hold ended too soon");
	a_suspend_entry: assert property (susp_req && !wd_roll && !brown
		|=> st == rst_pwr_pkg::ST_SUSPEND ##1 (!osc_run && !timers_run)) // RL8 RL9 RL13
		else $error("suspend request not honoured");
	a_no_stray_wake: assert property (st == rst_pwr_pkg::ST_SUSPEND && !wake
		|=> st inside {rst_pwr_pkg::ST_SUSPEND, rst_pwr_pkg::ST_SUPPLY_HOLD}) // RL10
		else $error("left suspend without a wake source");
	a_wake_needs_run: assert property (st == rst_pwr_pkg::ST_SUSPEND && !proc_status[`PS_RUN_BIT]
		|=> st != rst_pwr_pkg::ST_OSC_WAIT) // RL14
		else $error("resumed with run bit clear");
	a_gated_until_stable: assert property (st == rst_pwr_pkg::ST_OSC_WAIT && !osc_ok && !brown
		|=> st == rst_pwr_pkg::ST_OSC_WAIT ##1 !core_clk_en) // RL11 RL22
		else $error("resumed before oscillator stable");
	a_int_resume_len: assert property (st == rst_pwr_pkg::ST_RES_DELAY && tm_done && !ext_osc_sel
		|-> res_cnt == TW'(RES_INT_CYC)) // RL20
		else $error("internal clock resume delay wrong");
	a_defer_after_wake: assert property (st == rst_pwr_pkg::ST_RES_DELAY && tm_done && !brown
		|=> st == rst_pwr_pkg::ST_RUN && irq_defer) // RL15
		else $error("interrupt not deferred after wake");

	c_supply_recover: cover property (st == rst_pwr_pkg::ST_START && tm_done);
	c_wdog_reset: cover property (st == rst_pwr_pkg::ST_WDOG_HOLD && tm_done);
	c_suspend_resume: cover property (st == rst_pwr_pkg::ST_RES_DELAY && tm_done);
endmodule

/* rst_pwr_consts.svh */
// register map, field positions, reset values and timing figures of the reset/suspend block
`ifndef RST_PWR_CONSTS_SVH
`define RST_PWR_CONSTS_SVH

`define ADDR_WDOG_CLEAR   8'h26
`define ADDR_CLK_CFG      8'hF8
`define ADDR_PROC_STATUS  8'hFF

`define PS_RUN_BIT        0
`define PS_SENSE_BIT      2
`define PS_SUSPEND_BIT    3
`define PS_SUPPLY_BIT     4
`define PS_WDOG_BIT       6
`define PS_RESET_VAL      8'h11

`define CC_EXT_OSC_BIT    0
`define CC_UV_DIS_BIT     3
`define CC_RES_DLY_BIT    7
`define CC_RESET_VAL      8'h00

`define BOR_TRIP_MV       2500
`define RESET_VECTOR      14'h0000

`define CLK_MHZ           250
`define T_START_US        1000
`define T_WDOG_HOLD_MS    2
`define T_WATCH_MS        8
`define T_RES_EXT_LONG_US 4000
`define T_RES_EXT_SHORT_US 128
`define T_RES_INT_US      8

`endif

/* rst_pwr_pkg.sv */
// types shared by the reset and suspend control block
package rst_pwr_pkg;

	typedef enum logic [6:0] {
		ST_SUPPLY_HOLD = 7'h01,
		ST_START       = 7'h02,
		ST_RUN         = 7'h04,
		ST_SUSPEND     = 7'h08,
		ST_OSC_WAIT    = 7'h10,
		ST_RES_DELAY   = 7'h20,
		ST_WDOG_HOLD   = 7'h40
	} pwr_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] data;
	} io_req_t;

	typedef struct packed {
		logic [7:0] irq_pend;
		logic [7:0] irq_en;
		logic       spi_irq;
	} wake_src_t;

endpackage

/* span_timer.sv */
// one-shot down counter that times start-up, watchdog hold and resume delays
`timescale 1ns/1ns
module span_timer #(
	parameter int W = 20
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic         start,
	input  wire logic         abort,
	input  wire logic [W-1:0] len,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt;

	// done pulses len cycles after start
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt  <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				busy <= 1'b0;
			end else if (start) begin
				cnt  <= len;
				busy <= 1'b1;
			end else if (busy) begin
				if (cnt <= W'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt <= cnt - W'(1);
				end
			end
		end
	end
endmodule

/* watchdog_timer.sv */
// watchdog counter, cleared by firmware, pulses on rollover
`timescale 1ns/1ns
module watchdog_timer #(
	parameter int W      = 24,
	parameter int PERIOD = 2000000
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic         run,
	input  wire logic         clear,
	output logic [W-1:0]      count,
	output logic              roll
);
	// counts only while running; clear restarts from zero
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
			roll  <= 1'b0;
		end else begin
			roll <= 1'b0;
			if (clear) begin
				count <= '0;
			end else if (run) begin
				if (count == W'(PERIOD - 1)) begin
					count <= '0;
					roll  <= 1'b1;
				end else begin
					count <= count + W'(1);
				end
			end
		end
	end
endmodule

/* core_osc_model.sv */
// behavioural core and oscillator standing beside the reset and suspend block
`timescale 1ns/1ns
module core_osc_model #(
	parameter int OSC_START = 6,
	parameter int INSTR_GAP = 3
) (
	input  wire logic clk_sys,
	input  wire logic core_clk_en,
	input  wire logic core_rst,
	input  wire logic osc_run,
	output logic      osc_stable,
	output logic      core_instr_done
);
	int osc_cnt = 0;
	int ins_cnt = 0;

	// oscillator settles some cycles after enable and dies at once when stopped
	always_ff @(posedge clk_sys) begin
		osc_cnt <= osc_run ? ((osc_cnt < OSC_START) ? osc_cnt + 1 : osc_cnt) : 0;
	end

	// core retires an instruction every few cycles, never the first clocked cycle
	always_ff @(posedge clk_sys) begin
		ins_cnt <= (core_clk_en && !core_rst) ? ((ins_cnt == INSTR_GAP) ? 0 : ins_cnt + 1) : 0;
	end

	assign osc_stable      = (osc_cnt == OSC_START);
	assign core_instr_done = (ins_cnt == INSTR_GAP);
endmodule

/* brownout_watchdog_suspend_ctrl_test.sv */
// self-checking bench for the brown-out, watchdog and suspend control block
`timescale 1ns/1ns
`include "rst_pwr_consts.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
`define WAITC(cond, lim) begin n = 0; while (!(cond) && n < (lim)) begin \
	@(negedge clk_sys); n++; end end
module brownout_watchdog_suspend_ctrl_test;
	localparam int START_CYC = 20;
	localparam int HOLD_CYC  = 20;
	localparam int WATCH_CYC = 50;
	localparam int RES_LONG  = 30;
	localparam int RES_SHORT = 10;
	localparam int OSC_START = 6;
	localparam logic [7:0] CFGS [3] = '{8'h00, 8'h01, 8'h81};
	logic                   clk_sys = 0;
	logic                   nrst = 0;
	logic                   supply_drop_detect = 0;
	logic                   undervolt_detect = 0;
	logic                   ps2_serial_data_pin = 1;
	rst_pwr_pkg::io_req_t   io_req = '0;
	rst_pwr_pkg::wake_src_t wake_src = '0;
	logic                   osc_stable, core_instr_done, core_rst, core_clk_en, osc_run;
	logic                   ext_osc_sel, timers_run, undervolt_reset_armed, irq_defer;
	logic [7:0]             io_rdata, rv, cfg, ua;
	int                     err_count = 0;
	int                     checked = 0;
	int                     seed = 32'h699b;
	int                     n, k, w, len;

	// clock at 250 MHz
	always #2 clk_sys = ~clk_sys;

	rst_suspend_ctrl #(.START_CYC(START_CYC), .WDOG_HOLD_CYC(HOLD_CYC), .WATCH_CYC(WATCH_CYC),
		.RES_LONG_CYC(RES_LONG), .RES_SHORT_CYC(RES_SHORT)) rst_suspend_ctrl_i (
		.clk_sys(clk_sys), .nrst(nrst), .supply_drop_detect(supply_drop_detect),
		.undervolt_detect(undervolt_detect), .ps2_serial_data_pin(ps2_serial_data_pin),
		.osc_stable(osc_stable), .io_req(io_req), .wake_src(wake_src),
		.core_instr_done(core_instr_done), .io_rdata(io_rdata), .core_rst(core_rst),
		.core_clk_en(core_clk_en), .osc_run(osc_run), .ext_osc_sel(ext_osc_sel),
		.timers_run(timers_run), .undervolt_reset_armed(undervolt_reset_armed),
		.irq_defer(irq_defer));

	core_osc_model #(.OSC_START(OSC_START)) core_osc_model_i (.clk_sys(clk_sys),
		.core_clk_en(core_clk_en), .core_rst(core_rst), .osc_run(osc_run),
		.osc_stable(osc_stable), .core_instr_done(core_instr_done));

	// resume delay expected for a clock configuration value
	function automatic int res_len(input logic [7:0] c);
		return c[`CC_EXT_OSC_BIT] ? (c[`CC_RES_DLY_BIT] ? RES_LONG : RES_SHORT)
			: (`T_RES_INT_US * `CLK_MHZ);
	endfunction

	// one-cycle register write strobe
	task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		io_req.wr = 1'b1;
		io_req.addr = a;
		io_req.data = d;
		@(negedge clk_sys);
		io_req.wr = 1'b0;
	endtask

	// one-cycle read strobe, data taken once it has settled
	task automatic io_rd(input logic [7:0] a);
		@(negedge clk_sys);
		io_req.rd = 1'b1;
		io_req.addr = a;
		@(negedge clk_sys);
		io_req.rd = 1'b0;
		@(negedge clk_sys);
		rv = io_rdata;
	endtask

	task automatic complete_run();
		$display("checked %0d, err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard, several times the longest expected run
	initial begin
		#(4 * 20000);
		err_count++;
		complete_run();
	end

	initial begin
		repeat (8) @(negedge clk_sys);
		`CHK("core_rst in reset", 1'b1, core_rst)
		`CHK("armed in reset", 1'b1, undervolt_reset_armed)
		nrst = 1'b1;
		`WAITC(!core_rst, START_CYC + 30)
		`CHK("start delay", 1'b1, n >= START_CYC && n <= START_CYC + 10)
		io_rd(`ADDR_PROC_STATUS);
		`CHK("status reset", `PS_RESET_VAL, rv)
		io_rd(`ADDR_CLK_CFG);
		`CHK("cfg reset", `CC_RESET_VAL, rv)
		io_rd(`ADDR_WDOG_CLEAR);
		`CHK("clear reg reads zero", 8'h00, rv)
		ua = 8'($random(seed));
		if (ua == `ADDR_WDOG_CLEAR || ua == `ADDR_CLK_CFG || ua == `ADDR_PROC_STATUS) ua = 8'h30;
		io_rd(ua);
		`CHK("unmapped read", 8'h00, rv)
		io_wr(`ADDR_CLK_CFG, 8'h81);
		io_rd(`ADDR_CLK_CFG);
		`CHK("cfg write", 8'h81, rv)
		$display("test registers done");
		// clears at random spacing inside the period keep the core running
		for (k = 0; k < 8; k++) begin
			io_wr(`ADDR_WDOG_CLEAR, 8'($random(seed)));
			w = 5 + ($unsigned($random(seed)) % 40);
			`WAITC(core_rst, w)
			`CHK("no trip while cleared", w, n)
		end
		io_wr(`ADDR_WDOG_CLEAR, 8'h00);
		`WAITC(core_rst, WATCH_CYC + 20)
		`CHK("watchdog period", 1'b1, n >= WATCH_CYC && n <= WATCH_CYC + 4)
		io_rd(`ADDR_PROC_STATUS);
		`CHK("watchdog flag", 1'b1, rv[`PS_WDOG_BIT])
		`WAITC(!core_rst, HOLD_CYC + 20)
		`CHK("watchdog hold", 1'b1, n + 3 >= HOLD_CYC && n + 3 <= HOLD_CYC + 3)
		$display("test watchdog done");
		// suspend and resume for each clock choice and wake source
		for (k = 0; k < 3; k++) begin
			cfg = CFGS[k];
			len = res_len(cfg);
			io_wr(`ADDR_WDOG_CLEAR, 8'h5A);
			io_wr(`ADDR_CLK_CFG, cfg);
			wake_src.irq_pend = 8'hFF;
			if (k == 1) wake_src.spi_irq = 1'b1;
			io_wr(`ADDR_PROC_STATUS, 8'h09 | (8'($random(seed)) & 8'h04));
			if (k == 1) begin
				`WAITC(!osc_run, 4)
				`CHK("pending wake still suspends", 1'b1, n < 4)
			end else begin
				repeat (12) @(negedge clk_sys);
				`CHK("osc stopped", 1'b0, osc_run)
				`CHK("timers stopped", 1'b0, timers_run)
				`CHK("core clock off", 1'b0, core_clk_en)
				`CHK("undervolt off", 1'b0, undervolt_reset_armed)
				if (k == 0) wake_src.irq_en = 8'h01 << ($unsigned($random(seed)) % 8);
				else ps2_serial_data_pin = 1'b0;
			end
			`WAITC(core_clk_en, len + 40)
			`CHK("resume delay", 1'b1, n >= len && n <= len + OSC_START + 15)
			`CHK("wake clock", cfg[`CC_EXT_OSC_BIT], ext_osc_sel)
			`CHK("interrupt held off", 1'b1, irq_defer)
			wake_src = '0;
			ps2_serial_data_pin = 1'b1;
			`WAITC(!irq_defer, 10)
			`CHK("interrupts after one instr", 1'b1, n < 10)
			`CHK("undervolt restored", 1'b1, undervolt_reset_armed)
			$display("test suspend mode %0d done", k);
		end
		// run bit low blocks resume; brown-out still resets in suspend
		io_wr(`ADDR_WDOG_CLEAR, 8'h00);
		io_wr(`ADDR_PROC_STATUS, 8'h08);
		undervolt_detect = 1'b1;
		repeat (20) @(negedge clk_sys);
		`CHK("undervolt ignored in suspend", 1'b0, core_rst)
		ps2_serial_data_pin = 1'b0;
		repeat (40) @(negedge clk_sys);
		`CHK("no resume without run", 1'b0, osc_run)
		supply_drop_detect = 1'b1;
		`WAITC(core_rst, 8)
		`CHK("brown-out in suspend", 1'b1, n < 8)
		supply_drop_detect = 1'b0;
		undervolt_detect = 1'b1;
		ps2_serial_data_pin = 1'b1;
		repeat (40) @(negedge clk_sys);
		`CHK("held below threshold", 1'b1, core_rst)
		undervolt_detect = 1'b0;
		`WAITC(!core_rst, START_CYC + 30)
		`CHK("start delay again", 1'b1, n >= START_CYC && n <= START_CYC + 10)
		io_rd(`ADDR_PROC_STATUS);
		`CHK("supply flag", 1'b1, rv[`PS_SUPPLY_BIT])
		$display("test brown-out done");
		complete_run();
	end
endmodule
